// [logic/bm_monitor.sv]
`timescale 1ns/1ps
module bm_monitor #(
	parameter int QUEUE_DEPTH = bm_pkg::QUEUE_WORDS
) (
	input  wire logic               clk,
	input  wire logic               rstn,
	input  wire bm_pkg::bm_regaddr_t reg_addr,
	input  wire bm_pkg::bm_word_t   reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic [15:0]             reg_rdata,
	input  wire logic               rx_word_stb,
	input  wire bm_pkg::bm_word_t   rx_word,
	input  wire logic               rx_chan_b,
	input  wire logic               rx_cmd_sync,
	input  wire logic               rx_word_ok,
	input  wire logic [7:0]         rx_gap,
	input  wire logic               external_start_edge_input,
	output logic [15:0]             ram_addr,
	output logic [15:0]             ram_wdata,
	output logic                    ram_we,
	output logic                    ram_re,
	input  wire bm_pkg::bm_word_t   ram_rdata,
	output logic                    pattern_event,
	output logic                    eom_event
);
	import bm_pkg::*;

	localparam bm_word_t QMASK = 16'(QUEUE_DEPTH - 1);

	// ==========================================================
	// Registers
	bm_state_t  state_reg;
	bm_word_t   cfg_reg, mask_reg, trig_reg, qptr_reg, wm_cnt_reg, tag_reg, cmd_reg;
	bm_word_t   cptr_reg, dptr_reg, centry_reg, dstart_reg, rdata_reg;
	bm_word_t   ram_addr_reg, ram_wdata_reg;
	logic [4:0] own_reg;
	logic [6:0] remain_reg;
	logic [3:0] vec_reg;
	logic [1:0] desc_idx_reg;
	logic       ram_we_reg, ram_re_reg, rd_wait_reg, capture_reg, pat_hit_reg;
	logic       first_reg, err_reg, chan_reg, ext_prev_reg, pat_ev_reg, eom_ev_reg;

	// ==========================================================
	// Decoding
	wire bm_mode_t mode     = bm_mode_t'(cfg_reg[1:0]);
	wire       cfg_wr       = reg_wr && reg_addr == REG_CONFIG;
	wire       start_req    = cfg_wr && reg_wdata[CFG_START];
	wire       stop_req     = cfg_wr && reg_wdata[CFG_STOP];
	// START may arrive in the same write as the mode, so idle decisions use the incoming value
	wire bm_word_t cfg_now  = cfg_wr ? (reg_wdata & CFG_STORE_MASK) : cfg_reg;
	wire bm_mode_t mode_now = bm_mode_t'(cfg_now[1:0]);
	wire       cap_at_start = !(cfg_now[CFG_TRIG_EN] && !cfg_now[CFG_STOP_ON]); // [R9]
	wire       sm_start     = start_req && (mode_now == BM_SEL || mode_now == BM_RTMT);
	wire       qptr_wr      = reg_wr && reg_addr == REG_QUEUE_PTR;
	wire       pat_clr      = reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_PATTERN];
	wire       area_b       = cfg_reg[CFG_AREA_B];
	wire       ext_rise     = external_start_edge_input && !ext_prev_reg;
	wire       trig_en      = cfg_reg[CFG_TRIG_EN];
	wire       stop_on      = cfg_reg[CFG_STOP_ON];
	wire       in_run       = state_reg == S_RUN;
	wire       sm_mode      = mode == BM_SEL || mode == BM_RTMT;
	wire       armed        = in_run && mode == BM_WORD && !capture_reg;

	// Single compare word serves trigger and pattern event alike
	wire       pattern_match = in_run && mode == BM_WORD && rx_word_stb && rx_word == trig_reg; // [R7]
	wire       trig_start   = pattern_match && trig_en && !stop_on && !capture_reg; // [R9]
	wire       trig_stop    = pattern_match && trig_en && stop_on && capture_reg;   // [R9]
	wire       wm_store     = in_run && mode == BM_WORD && rx_word_stb && (capture_reg || trig_start); // [R1]
	wire bm_word_t wm_mask  = cfg_reg[CFG_RAM_4K] ? WM_MASK_4K : WM_MASK_64K;
	wire bm_word_t wm_step  = (wm_cnt_reg + 16'h0001) & wm_mask; // [R5]
	wire bm_word_t wm_tag   = {rx_chan_b, !rx_word_ok, rx_cmd_sync, 5'h00, rx_gap}; // [R3]

	// Combined mode leaves own address and broadcast to the terminal side
	wire       skip_own     = mode == BM_RTMT &&
	                          (rx_word[15:11] == own_reg || rx_word[15:11] == BCAST_ADDR); // [R20]
	wire       sm_cmd       = in_run && sm_mode && rx_word_stb && rx_cmd_sync && rx_word_ok; // [R11]
	wire bm_word_t flt_addr = FILTER_BASE | {9'h000, rx_word[15:9]}; // [R12]
	wire       flt_bit      = ram_rdata[cmd_reg[8:5]]; // [R13]
	wire bm_word_t cptr_loc = area_b ? SM_CPTR_B : SM_CPTR_A; // [R17]
	wire bm_word_t dptr_loc = area_b ? SM_DPTR_B : SM_DPTR_A; // [R17]

	// Stack stepping and half/full crossing detection
	wire bm_word_t cmask    = cmd_stack_mask(cfg_reg[CFG_CSIZE +: 2]); // [R18]
	wire bm_word_t dmask    = data_stack_mask(cfg_reg[CFG_DSIZE +: 3]); // [R19]
	wire bm_word_t chalf    = cmask ^ (cmask >> 1);
	wire bm_word_t dhalf    = dmask ^ (dmask >> 1);
	wire bm_word_t cptr_nx  = stack_step(cptr_reg, cmask);
	wire bm_word_t dptr_nx  = stack_step(dptr_reg, dmask);
	wire       cs50         = |(cptr_nx & chalf) && !(|(cptr_reg & chalf)); // [R21]
	wire       cs100        = (cptr_nx & cmask) == RST_WORD;                 // [R21]
	wire       ds50         = |(dptr_nx & dhalf) && !(|(dptr_reg & dhalf)); // [R21]
	wire       ds100        = (dptr_nx & dmask) == RST_WORD;                 // [R21]

	// A receive command followed at once by a transmit command is a terminal-to-terminal pair
	wire       sm_word      = state_reg == S_MSG && rx_word_stb;
	wire       rtrt         = sm_word && first_reg && rx_cmd_sync && !cmd_reg[10] && rx_word[10];

	// Vector: bit 0 marks a message entry, event bits gated by the mask
	wire bm_word_t vector   = {10'h000, vec_reg & mask_reg[5:2], mask_reg[MSK_EOM], 1'b1}; // [R24]
	wire       q_ok         = |vector[5:1] && (err_reg ? cfg_reg[CFG_Q_INVAL]
	                                                    : cfg_reg[CFG_Q_VALID]); // [R22]
	wire bm_word_t qptr_nx  = stack_step(qptr_reg, QMASK); // [R25]

	// Words left after the command: data words plus status, none for broadcast status
	function automatic logic [6:0] msg_words(bm_word_t c);
		logic [6:0] data;
		logic [6:0] stat;
		data = 7'h00;
		if (c[9:5] == MC_SA_LO || c[9:5] == MC_SA_HI) begin
			data = {6'h00, c[4]};
		end else if (c[4:0] == 5'h00) begin
			data = MAX_WC;
		end else begin
			data = {2'h0, c[4:0]};
		end
		stat = (c[15:11] == BCAST_ADDR) ? 7'h00 : 7'h01;
		return data + stat;
	endfunction
	wire [6:0] cmd_len = msg_words(cmd_reg);

	// Register read selection
	bm_word_t rd_sel;
	always_comb begin
		if (reg_addr == REG_CONFIG) begin
			rd_sel = cfg_reg;
		end else if (reg_addr == REG_IRQ_MASK) begin
			rd_sel = mask_reg;
		end else if (reg_addr == REG_TRIG_WORD) begin
			rd_sel = trig_reg;
		end else if (reg_addr == REG_DSTACK_ADDR) begin
			rd_sel = (mode == BM_WORD) ? wm_cnt_reg : dptr_reg; // [R5]
		end else if (reg_addr == REG_QUEUE_PTR) begin
			rd_sel = qptr_reg;
		end else if (reg_addr == REG_STATUS) begin
			rd_sel = {12'h000, state_reg == S_MSG, pat_hit_reg, armed, state_reg != S_IDLE};
		end else if (reg_addr == REG_OWN_ADDR) begin
			rd_sel = {11'h000, own_reg};
		end else begin
			rd_sel = RST_WORD;
		end
	end

	// ==========================================================
	// Host registers
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cfg_reg      <= RST_WORD;
			mask_reg     <= RST_WORD;
			trig_reg     <= RST_WORD;
			own_reg      <= 5'h00;
			rdata_reg    <= RST_WORD;
			pat_hit_reg  <= 1'b0;
			pat_ev_reg   <= 1'b0;
			ext_prev_reg <= 1'b0;
		end else begin
			if (cfg_wr) begin
				cfg_reg <= reg_wdata & CFG_STORE_MASK;
			end
			if (reg_wr && reg_addr == REG_IRQ_MASK) begin
				mask_reg <= reg_wdata;
			end
			if (reg_wr && reg_addr == REG_TRIG_WORD) begin
				trig_reg <= reg_wdata;
			end
			if (reg_wr && reg_addr == REG_OWN_ADDR) begin
				own_reg <= reg_wdata[4:0];
			end
			rdata_reg    <= reg_rd ? rd_sel : RST_WORD;
			pat_ev_reg   <= pattern_match && mask_reg[MSK_PATTERN]; // [R8]
			// Set wins over a clear in the same cycle
			pat_hit_reg  <= (pattern_match && mask_reg[MSK_PATTERN]) || (pat_hit_reg && !pat_clr);
			ext_prev_reg <= external_start_edge_input;
		end
	end

	// ==========================================================
	// Sequencer: one RAM access per cycle, reads answer two cycles after issue
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_reg     <= S_IDLE;
			ram_addr_reg  <= RST_WORD;
			ram_wdata_reg <= RST_WORD;
			ram_we_reg    <= 1'b0;
			ram_re_reg    <= 1'b0;
			rd_wait_reg   <= 1'b0;
			capture_reg   <= 1'b0;
			wm_cnt_reg    <= RST_WORD;
			tag_reg       <= RST_WORD;
			cmd_reg       <= RST_WORD;
			cptr_reg      <= RST_WORD;
			dptr_reg      <= RST_WORD;
			centry_reg    <= RST_WORD;
			dstart_reg    <= RST_WORD;
			qptr_reg      <= RST_WORD;
			remain_reg    <= 7'h00;
			vec_reg       <= 4'h0;
			desc_idx_reg  <= 2'h0;
			first_reg     <= 1'b0;
			err_reg       <= 1'b0;
			chan_reg      <= 1'b0;
			eom_ev_reg    <= 1'b0;
		end else begin
			ram_we_reg  <= 1'b0;
			ram_re_reg  <= 1'b0;
			rd_wait_reg <= 1'b0;
			eom_ev_reg  <= 1'b0;
			case (state_reg)
				S_IDLE: begin
					if (mode_now == BM_WORD && (start_req || ext_rise)) begin // [R10]
						ram_addr_reg <= cfg_now[CFG_AREA_B] ? WM_PTR_B : WM_PTR_A; // [R4]
						ram_re_reg   <= 1'b1;
						rd_wait_reg  <= 1'b1;
						capture_reg  <= ext_rise || cap_at_start; // [R9]
						state_reg    <= S_PTR_WAIT;
					end else if (sm_start) begin
						state_reg <= S_RUN;
					end
				end
				S_PTR_WAIT: begin
					if (!rd_wait_reg) begin
						wm_cnt_reg <= ram_rdata; // [R4]
						state_reg  <= S_RUN;
					end
				end
				S_RUN: begin
					if (mode == BM_WORD && ext_rise) begin
						capture_reg <= 1'b1; // [R10]
					end
					if (wm_store) begin
						// Pointer words at 0100/0104 are written over like any other
						ram_addr_reg  <= wm_cnt_reg; // [R6]
						ram_wdata_reg <= rx_word;    // [R2]
						ram_we_reg    <= 1'b1;
						wm_cnt_reg    <= wm_step;
						tag_reg       <= wm_tag;
						state_reg     <= S_TAG;
						if (trig_start) begin
							capture_reg <= 1'b1; // [R9]
						end else if (trig_stop) begin
							capture_reg <= 1'b0; // [R9]
						end
					end else if (sm_cmd && !skip_own) begin // [R20]
						cmd_reg      <= rx_word;
						chan_reg     <= rx_chan_b;
						ram_addr_reg <= flt_addr; // [R12]
						ram_re_reg   <= 1'b1;
						rd_wait_reg  <= 1'b1;
						state_reg    <= S_FLT_WAIT;
					end
				end
				S_TAG: begin
					ram_addr_reg  <= wm_cnt_reg;
					ram_wdata_reg <= tag_reg; // [R2]
					ram_we_reg    <= 1'b1;
					wm_cnt_reg    <= wm_step; // [R5]
					state_reg     <= S_RUN;
				end
				S_FLT_WAIT: begin
					if (!rd_wait_reg) begin
						if (flt_bit) begin // [R14]
							ram_addr_reg <= cptr_loc; // [R26]
							ram_re_reg   <= 1'b1;
							rd_wait_reg  <= 1'b1;
							state_reg    <= S_CPTR_WAIT;
						end else begin
							state_reg <= S_RUN; // [R14]
						end
					end
				end
				S_CPTR_WAIT: begin
					if (!rd_wait_reg) begin
						cptr_reg     <= ram_rdata; // [R17]
						centry_reg   <= ram_rdata;
						ram_addr_reg <= dptr_loc;
						ram_re_reg   <= 1'b1;
						rd_wait_reg  <= 1'b1;
						state_reg    <= S_DPTR_WAIT;
					end
				end
				S_DPTR_WAIT: begin
					if (!rd_wait_reg) begin
						dptr_reg     <= ram_rdata; // [R17]
						dstart_reg   <= ram_rdata;
						remain_reg   <= cmd_len;
						first_reg    <= 1'b1;
						err_reg      <= 1'b0;
						vec_reg      <= 4'h0;
						desc_idx_reg <= 2'h0;
						state_reg    <= (cmd_len == 7'h00) ? S_DESC : S_MSG;
					end
				end
				S_MSG: begin
					if (sm_word) begin
						// Data, status and a second command all go to the data stack
						ram_addr_reg  <= dptr_reg;  // [R16]
						ram_wdata_reg <= rx_word;   // [R15]
						ram_we_reg    <= 1'b1;
						dptr_reg      <= dptr_nx;   // [R19]
						vec_reg[2]    <= vec_reg[2] | ds50;
						vec_reg[3]    <= vec_reg[3] | ds100;
						first_reg     <= 1'b0;
						if (rtrt) begin
							remain_reg <= remain_reg + 7'h01; // [R15]
						end else begin
							remain_reg <= remain_reg - 7'h01;
						end
						if (!rx_word_ok) begin
							err_reg   <= 1'b1;
							state_reg <= S_DESC;
						end else if (!rtrt && remain_reg == 7'h01) begin
							state_reg <= S_DESC; // [R11]
						end
					end
				end
				S_DESC: begin
					// Entry: block status, unused time slot, data start, command word
					ram_addr_reg <= cptr_reg; // [R14]
					ram_we_reg   <= 1'b1;
					case (desc_idx_reg)
						2'h0: ram_wdata_reg <= {1'b1, 1'b0, chan_reg, err_reg, 12'h000};
						2'h1: ram_wdata_reg <= RST_WORD;
						2'h2: ram_wdata_reg <= dstart_reg;
						default: ram_wdata_reg <= cmd_reg; // [R16]
					endcase
					cptr_reg     <= cptr_nx; // [R18]
					vec_reg[0]   <= vec_reg[0] | cs50;
					vec_reg[1]   <= vec_reg[1] | cs100;
					desc_idx_reg <= desc_idx_reg + 2'h1;
					if (desc_idx_reg == DESC_LAST) begin
						state_reg <= S_PW_C;
					end
				end
				S_PW_C: begin
					ram_addr_reg  <= cptr_loc;
					ram_wdata_reg <= cptr_reg;
					ram_we_reg    <= 1'b1;
					state_reg     <= S_PW_D;
				end
				S_PW_D: begin
					ram_addr_reg  <= dptr_loc;
					ram_wdata_reg <= dptr_reg;
					ram_we_reg    <= 1'b1;
					eom_ev_reg    <= 1'b1; // [R21]
					state_reg     <= q_ok ? S_Q_VEC : S_RUN; // [R22]
				end
				S_Q_VEC: begin
					ram_addr_reg  <= qptr_reg;
					ram_wdata_reg <= vector;  // [R23]
					ram_we_reg    <= 1'b1;
					qptr_reg      <= qptr_nx; // [R25]
					state_reg     <= S_Q_PAR;
				end
				S_Q_PAR: begin
					ram_addr_reg  <= qptr_reg;
					ram_wdata_reg <= centry_reg; // [R23]
					ram_we_reg    <= 1'b1;
					qptr_reg      <= qptr_nx;    // [R25]
					state_reg     <= S_RUN;
				end
				default: state_reg <= S_IDLE;
			endcase
			if (qptr_wr) begin
				qptr_reg <= reg_wdata; // [R25]
			end
			// Stopping mid-message drops the pointer write-back
			if (stop_req) begin
				state_reg   <= S_IDLE;
				capture_reg <= 1'b0;
			end
		end
	end

	assign reg_rdata     = rdata_reg;
	assign ram_addr      = ram_addr_reg;
	assign ram_wdata     = ram_wdata_reg;
	assign ram_we        = ram_we_reg;
	assign ram_re        = ram_re_reg;
	assign pattern_event = pat_ev_reg;
	assign eom_event     = eom_ev_reg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	wm_pair_a: assert property (wm_store |=> ram_we && ram_wdata == $past(rx_word) ##1 // [R2]
		ram_we && ram_wdata[15] == $past(rx_chan_b, 2) && ram_wdata[14] == !$past(rx_word_ok, 2))
		else $error("word and tag pair not written");
	wm_wrap_a: assert property (state_reg == S_TAG && cfg_reg[CFG_RAM_4K] && // [R5]
		wm_cnt_reg == WM_MASK_4K |=> wm_cnt_reg == RST_WORD)
		else $error("4K counter did not wrap");
	start_ptr_a: assert property (state_reg == S_PTR_WAIT && !rd_wait_reg // [R4]
		|=> wm_cnt_reg == $past(ram_rdata) && state_reg == S_RUN)
		else $error("start pointer not loaded");
	ext_start_a: assert property (state_reg == S_IDLE && ext_rise && mode_now == BM_WORD && !stop_req // [R10]
		|=> ram_re && ram_addr == ($past(cfg_now[CFG_AREA_B]) ? WM_PTR_B : WM_PTR_A))
		else $error("external edge did not start monitor");
	pat_irq_a: assert property (pattern_event |-> $past(mask_reg[MSK_PATTERN]) && $past(pattern_match)) // [R8]
		else $error("pattern event without enable");
	trig_stop_a: assert property (trig_stop && !stop_req |=> !capture_reg) // [R9]
		else $error("stop trigger ignored");
	flt_addr_a: assert property (state_reg == S_FLT_WAIT && rd_wait_reg // [R12]
		|-> ram_re && ram_addr == (FILTER_BASE | {9'h000, cmd_reg[15:9]}))
		else $error("filter address wrong");
	flt_drop_a: assert property (state_reg == S_FLT_WAIT && !rd_wait_reg && !flt_bit && !stop_req // [R14]
		|=> state_reg == S_RUN && !ram_we)
		else $error("filtered message not dropped");
	flt_pass_a: assert property (state_reg == S_FLT_WAIT && !rd_wait_reg && flt_bit && !stop_req // [R13]
		|=> ram_re && ram_addr == $past(cptr_loc))
		else $error("enabled command not fetched");
	own_skip_a: assert property (sm_cmd && skip_own && !stop_req |=> state_reg == S_RUN && !ram_re) // [R20]
		else $error("own address monitored");
	eom_a: assert property (state_reg == S_PW_D && !stop_req |=> eom_event) // [R21]
		else $error("end of message not flagged");
	q_pair_a: assert property (state_reg == S_Q_PAR |-> ram_we && ram_wdata[0] // [R24]
		##1 ram_we && ram_wdata == $past(centry_reg))
		else $error("queue entry malformed");
	q_wrap_a: assert property (state_reg == S_Q_PAR && !qptr_wr // [R25]
		|=> qptr_reg == stack_step($past(qptr_reg), QMASK))
		else $error("queue pointer step wrong");

	wm_store_c: cover property (wm_store ##2 wm_store);
	flt_pass_c: cover property (state_reg == S_FLT_WAIT && !rd_wait_reg && flt_bit);
	rtrt_c:     cover property (rtrt);
	queue_c:    cover property (state_reg == S_Q_PAR);
endmodule

// [shared/bm_pkg.sv]
// Behaviour
// [R1] Word monitor captures every command, status and data word from both buses.
// [R2] Each captured word stores two RAM words: bus word then its tag word.
// [R3] Tag word encodes bus channel, word validity and inter-word gap.
// [R4] Word monitor starts storing at address read from pointer location 0100 (area A).
// [R5] Host-readable write counter wraps to 0000 after FFFF, or 0FFF for 4K RAM.
// [R6] Pointer locations 0100 and 0104 are not protected from being overwritten.
// [R7] Captured words compare against one 16-bit pattern for trigger and interrupt.
// [R8] Pattern-match interrupt only when its enable bit in mask register is set.
// [R9] Pattern trigger acts only when enabled; configuration chooses start or stop.
// [R10] Rising edge on external trigger input starts word monitoring.
// [R11] Selective monitor separates command from status words itself to find messages.
// [R12] Filter address: bits 9,7 set, terminal address, direction, subaddress bit 4.
// [R13] Subaddress bits 3-0 pick the filter bit in the addressed word.
// [R14] Filter bit zero drops message; one builds command entry and data stack words.
// [R15] Terminal-to-terminal: accepted receive command stores the transmit command too.
// [R16] Receive message: command in command entry, data then status in data stack.
// [R17] Stack pointers at 102/106 and 103/107; filter table spans 0280-02FF.
// [R18] Command stack size selectable: 256, 1K, 4K or 16K words.
// [R19] Data stack size selectable: 512 words up to 64K words in powers of two.
// [R20] Combined mode skips own and broadcast address, monitors the remaining 30.
// [R21] End-of-message and 50%/100% stack interrupts for both stacks.
// [R22] Interrupt queue 64 words, 32 messages, filtered by valid or invalid messages.
// [R23] Queue entry is vector word then parameter pointing to block status word.
// [R24] Vector bit 0 is one for message events, zero otherwise, never both.
// [R25] Queue pointer names next free location, wraps modulo 64, host initialises.
// [R26] Host must initialise stack pointers, filter table and queue pointer first.
package bm_pkg;
	typedef logic [15:0] bm_word_t;
	typedef logic [3:0]  bm_regaddr_t;
	typedef enum logic [1:0] {BM_OFF = 2'h0, BM_WORD = 2'h1, BM_SEL = 2'h2, BM_RTMT = 2'h3} bm_mode_t;
	// Gray steps along word path and along message path
	typedef enum logic [3:0] {
		S_IDLE = 4'h0, S_PTR_WAIT = 4'h1, S_RUN = 4'h3, S_TAG = 4'h2,
		S_FLT_WAIT = 4'h7, S_CPTR_WAIT = 4'h5, S_DPTR_WAIT = 4'h4, S_MSG = 4'hC,
		S_DESC = 4'hD, S_PW_C = 4'hF, S_PW_D = 4'hE, S_Q_VEC = 4'hA, S_Q_PAR = 4'hB
	} bm_state_t;
	// ==========================================================
	// Register map
	localparam bm_regaddr_t REG_CONFIG      = 4'h0;
	localparam bm_regaddr_t REG_IRQ_MASK    = 4'h1;
	localparam bm_regaddr_t REG_TRIG_WORD   = 4'h2;
	localparam bm_regaddr_t REG_DSTACK_ADDR = 4'h3;
	localparam bm_regaddr_t REG_QUEUE_PTR   = 4'h4;
	localparam bm_regaddr_t REG_STATUS      = 4'h5;
	localparam bm_regaddr_t REG_OWN_ADDR    = 4'h6;
	localparam int CFG_TRIG_EN = 2;
	localparam int CFG_STOP_ON = 3;
	localparam int CFG_START   = 4;
	localparam int CFG_RAM_4K  = 5;
	localparam int CFG_AREA_B  = 6;
	localparam int CFG_CSIZE   = 7;
	localparam int CFG_DSIZE   = 9;
	localparam int CFG_Q_VALID = 12;
	localparam int CFG_Q_INVAL = 13;
	localparam int CFG_STOP    = 14;
	localparam bm_word_t CFG_STORE_MASK = 16'h3FEF;
	localparam int MSK_PATTERN = 0;
	localparam int MSK_EOM     = 1;
	localparam int ST_PATTERN  = 2;
	localparam bm_word_t RST_WORD = 16'h0000;
	// ==========================================================
	// Fixed RAM locations and bus word fields
	localparam bm_word_t WM_PTR_A    = 16'h0100;
	localparam bm_word_t WM_PTR_B    = 16'h0104;
	localparam bm_word_t SM_CPTR_A   = 16'h0102;
	localparam bm_word_t SM_DPTR_A   = 16'h0103;
	localparam bm_word_t SM_CPTR_B   = 16'h0106;
	localparam bm_word_t SM_DPTR_B   = 16'h0107;
	localparam bm_word_t FILTER_BASE = 16'h0280;
	localparam bm_word_t WM_MASK_64K = 16'hFFFF;
	localparam bm_word_t WM_MASK_4K  = 16'h0FFF;
	localparam int QUEUE_WORDS = 64;
	localparam logic [4:0] BCAST_ADDR = 5'h1F;
	localparam logic [4:0] MC_SA_LO   = 5'h00;
	localparam logic [4:0] MC_SA_HI   = 5'h1F;
	localparam logic [6:0] MAX_WC     = 7'h20;
	localparam logic [1:0] DESC_LAST  = 2'h3;
	// ==========================================================
	// Circular step inside a power-of-two stack
	function automatic bm_word_t stack_step(bm_word_t ptr, bm_word_t mask);
		return (ptr & ~mask) | ((ptr + 16'h0001) & mask);
	endfunction
	function automatic bm_word_t cmd_stack_mask(logic [1:0] code);
		case (code)
			2'h0: return 16'h00FF;
			2'h1: return 16'h03FF;
			2'h2: return 16'h0FFF;
			default: return 16'h3FFF;
		endcase
	endfunction
	function automatic bm_word_t data_stack_mask(logic [2:0] code);
		return (16'h01FF << code) | 16'h01FF;
	endfunction
endpackage

// [tb/bm_ram_model.sv]
`timescale 1ns/1ps
// ==========================================================
// Shared RAM seen by the monitor
module bm_ram_model (
	input  wire logic             clk,
	input  wire bm_pkg::bm_word_t ram_addr,
	input  wire bm_pkg::bm_word_t ram_wdata,
	input  wire logic             ram_we,
	input  wire logic             ram_re,
	output bm_pkg::bm_word_t      ram_rdata
);
	import bm_pkg::*;
	bm_word_t mem [0:65535];
	initial ram_rdata = 16'h5A5A;
	// Read data holds only the cycle after the strobe; scrambled otherwise so stale data fails
	always @(posedge clk) begin
		if (ram_we)
			mem[ram_addr] <= ram_wdata;
		if (ram_re)
			ram_rdata <= mem[ram_addr];
		else
			ram_rdata <= ~ram_rdata;
	end
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	import bm_pkg::*;
	logic        clk, rstn, reg_wr, reg_rd, stb, chb, cs, ok, ext, pev, eev, we, re;
	bm_regaddr_t ra;
	bm_word_t    wd, rdat, rw, ma, mw, mr, rv;
	logic [7:0]  gap;
	int          n_errors, check_count, pc, ec, cyc;
	bm_monitor bm_monitor_inst (.clk(clk), .rstn(rstn), .reg_addr(ra), .reg_wdata(wd),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdat), .rx_word_stb(stb),
		.rx_word(rw), .rx_chan_b(chb), .rx_cmd_sync(cs), .rx_word_ok(ok), .rx_gap(gap),
		.external_start_edge_input(ext), .ram_addr(ma), .ram_wdata(mw), .ram_we(we),
		.ram_re(re), .ram_rdata(mr), .pattern_event(pev), .eom_event(eev));
	bm_ram_model bm_ram_model_inst (.clk(clk), .ram_addr(ma), .ram_wdata(mw),
		.ram_we(we), .ram_re(re), .ram_rdata(mr));
	always #5 clk = ~clk;
	// Event pulse counters and a hang limit well above the expected run
	always @(posedge clk) begin
		cyc++;
		if (pev === 1'b1)
			pc++;
		if (eev === 1'b1)
			ec++;
		if (cyc == 20000) begin
			n_errors++;
			conclude();
		end
	end
	// ==========================================================
	// Access tasks
	task automatic chk(string nm, bm_word_t e, bm_word_t g);
		check_count++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask
	task automatic wr(bm_regaddr_t a, bm_word_t d);
		@(posedge clk);
		ra <= a;
		wd <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(bm_regaddr_t a);
		@(posedge clk);
		ra <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rv = rdat;
	endtask
	// Words spaced well past the minimum gap so no word lands in a pointer read
	task automatic send(bm_word_t w, logic b, logic c, logic k, logic [7:0] g);
		@(posedge clk);
		rw <= w;
		chb <= b;
		cs <= c;
		ok <= k;
		gap <= g;
		stb <= 1'b1;
		@(posedge clk);
		stb <= 1'b0;
		repeat (14) @(posedge clk);
	endtask
	task automatic conclude();
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	initial begin
		{clk, rstn, reg_wr, reg_rd, stb, chb, cs, ext} = '0;
		{ok, n_errors, check_count, pc, ec, cyc} = '0;
		{ra, wd, rw, gap} = '0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		rd(REG_STATUS);
		chk("status", RST_WORD, rv);
		// Start just below the pointer location so the run overwrites it
		bm_ram_model_inst.mem[WM_PTR_A] = 16'h00FE;
		wr(REG_CONFIG, 16'h0011);
		repeat (5) @(posedge clk);
		send(16'h1234, 1'b0, 1'b0, 1'b1, 8'h05);
		send(16'h5678, 1'b0, 1'b0, 1'b1, 8'h06);
		chk("wm_word", 16'h1234, bm_ram_model_inst.mem[16'h00FE]);
		chk("wm_tag", 16'h0005, bm_ram_model_inst.mem[16'h00FF]);
		chk("wm_over", 16'h5678, bm_ram_model_inst.mem[WM_PTR_A]);
		wr(REG_CONFIG, 16'h4000);
		// 4K RAM, external edge start, pattern interrupt on then off
		bm_ram_model_inst.mem[WM_PTR_A] = 16'h0FFE;
		wr(REG_IRQ_MASK, 16'h0001);
		wr(REG_TRIG_WORD, 16'hA5A5);
		wr(REG_CONFIG, 16'h0021);
		@(posedge clk);
		ext <= 1'b1;
		repeat (5) @(posedge clk);
		send(16'hA5A5, 1'b0, 1'b0, 1'b1, 8'h03);
		send(16'hC003, 1'b1, 1'b1, 1'b0, 8'h7E);
		wr(REG_IRQ_MASK, 16'h0000);
		send(16'hA5A5, 1'b0, 1'b0, 1'b1, 8'h03);
		chk("tag4k", 16'h0003, bm_ram_model_inst.mem[16'h0FFF]);
		chk("wrap", 16'hC003, bm_ram_model_inst.mem[16'h0000]);
		chk("tag_b", 16'hE07E, bm_ram_model_inst.mem[16'h0001]);
		chk("pat_cnt", 16'h0001, pc[15:0]);
		rd(REG_DSTACK_ADDR);
		chk("counter", 16'h0004, rv);
		rd(REG_STATUS);
		chk("pat_hit", 16'h0004, rv & 16'h0004);
		wr(REG_CONFIG, 16'h4000);
		// Selective: RT 5 receive SA 2 passes and is queued, SA 3 in same table word is dropped
		bm_ram_model_inst.mem[SM_CPTR_A] = 16'h0400;
		bm_ram_model_inst.mem[SM_DPTR_A] = 16'h0800;
		bm_ram_model_inst.mem[16'h0294] = 16'h0004;
		// Queue two slots below a 64-word boundary so the pointer must wrap
		wr(REG_QUEUE_PTR, 16'h007E);
		wr(REG_IRQ_MASK, 16'h0002);
		wr(REG_CONFIG, 16'h1012);
		repeat (5) @(posedge clk);
		send(16'h2842, 1'b0, 1'b1, 1'b1, 8'h00);
		send(16'h1111, 1'b0, 1'b0, 1'b1, 8'h00);
		send(16'h2222, 1'b0, 1'b0, 1'b1, 8'h00);
		send(16'h2800, 1'b0, 1'b1, 1'b1, 8'h00);
		repeat (10) @(posedge clk);
		chk("d0", 16'h1111, bm_ram_model_inst.mem[16'h0800]);
		chk("d1", 16'h2222, bm_ram_model_inst.mem[16'h0801]);
		chk("stat", 16'h2800, bm_ram_model_inst.mem[16'h0802]);
		chk("d_start", 16'h0800, bm_ram_model_inst.mem[16'h0402]);
		chk("cmd", 16'h2842, bm_ram_model_inst.mem[16'h0403]);
		chk("dptr", 16'h0803, bm_ram_model_inst.mem[SM_DPTR_A]);
		chk("q_vec", 16'h0003, bm_ram_model_inst.mem[16'h007E]);
		chk("q_par", 16'h0400, bm_ram_model_inst.mem[16'h007F]);
		rd(REG_QUEUE_PTR);
		chk("q_ptr", 16'h0040, rv);
		send(16'h2862, 1'b0, 1'b1, 1'b1, 8'h00);
		send(16'h3333, 1'b0, 1'b0, 1'b1, 8'h00);
		send(16'h4444, 1'b0, 1'b0, 1'b1, 8'h00);
		send(16'h2800, 1'b0, 1'b1, 1'b1, 8'h00);
		repeat (10) @(posedge clk);
		chk("eom_cnt", 16'h0001, ec[15:0]);
		chk("dptr_kept", 16'h0803, bm_ram_model_inst.mem[SM_DPTR_A]);
		// Combined mode: own address 5 stays with the terminal side, no message opens
		wr(REG_CONFIG, 16'h4000);
		wr(REG_OWN_ADDR, 16'h0005);
		wr(REG_CONFIG, 16'h0013);
		repeat (5) @(posedge clk);
		send(16'h2842, 1'b0, 1'b1, 1'b1, 8'h00);
		rd(REG_STATUS);
		chk("own_skip", 16'h0001, rv & 16'h0009);
		// Start-on-trigger skips words before the match, stop-on-trigger ends capture
		wr(REG_CONFIG, 16'h4000);
		bm_ram_model_inst.mem[WM_PTR_A] = 16'h0200;
		wr(REG_CONFIG, 16'h0015);
		repeat (5) @(posedge clk);
		send(16'h1111, 1'b0, 1'b0, 1'b1, 8'h00);
		send(16'hA5A5, 1'b0, 1'b0, 1'b1, 8'h00);
		wr(REG_CONFIG, 16'h000D);
		send(16'hA5A5, 1'b0, 1'b0, 1'b1, 8'h00);
		send(16'h2222, 1'b0, 1'b0, 1'b1, 8'h00);
		chk("trig_start", 16'hA5A5, bm_ram_model_inst.mem[16'h0200]);
		rd(REG_DSTACK_ADDR);
		chk("trig_stop", 16'h0204, rv);
		conclude();
	end
endmodule
